// file: rtl/dhi_pkg.sv
// Shared constants and types for the display host port and its host end
// Assumes both ends run on one 125 MHz system clock
package dhi_pkg;
	localparam int          DATA_W      = 8;
	localparam int          STRAP_W     = 3;
	localparam int          FIFO_DEPTH  = 8;
	localparam int          SPI_BITS    = 8;
	localparam int          SPI3_BITS   = 9;
	localparam int          DIV_HALF    = 10;
	localparam int          STB_HOLD    = 6;
	localparam int          RD_LAT      = 3;
	// Interface select strap codes
	localparam logic [2:0]  SEL_I2C     = 3'h0;
	localparam logic [2:0]  SEL_SPI3    = 3'h1;
	localparam logic [2:0]  SEL_SPI4    = 3'h2;
	localparam logic [2:0]  SEL_PAR_SEP = 3'h4;
	localparam logic [2:0]  SEL_PAR_EN  = 3'h6;
	localparam logic [7:0]  STATUS_RST  = 8'h00;
	localparam logic [7:0]  RAM_RST     = 8'h00;
	typedef enum logic [1:0] {
		OP_WR_CMD,
		OP_WR_DATA,
		OP_RD_STATUS,
		OP_RD_DATA
	} op_t;
endpackage

// file: rtl/dhi_if.sv
// Pin bundle between the host end and the display port end
// Wire level of the shared data bus is resolved by the bench from the enables
`timescale 1ns/1ps
interface dhi_if;
	logic [7:0] d_host;
	logic [7:0] d_host_oe_n;
	logic [7:0] d_dev;
	logic [7:0] d_dev_oe_n;
	logic [7:0] d_in_host;
	logic [7:0] d_in_dev;
	logic       cs_n;
	logic       dc;
	logic       e_rd_n;
	logic       rw_wr_n;
	logic [2:0] interface_select_straps;
	logic       reset_input_n;
	modport dev (
		output d_dev, d_dev_oe_n,
		input  d_in_dev, cs_n, dc, e_rd_n, rw_wr_n, interface_select_straps, reset_input_n
	);
	modport host (
		output d_host, d_host_oe_n, cs_n, dc, e_rd_n, rw_wr_n, interface_select_straps,
		       reset_input_n,
		input  d_in_host
	);
endinterface // dhi_if

// file: rtl/dhi_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
// Assumes one clock for both sides
`timescale 1ns/1ps
module dhi_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             i_mclk,
	input  wire logic             i_nrst,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	output logic      [WIDTH-1:0] o_data,
	output logic                  o_valid,
	input  wire logic             i_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
	logic             push, pop;

	always_comb begin
		push = i_valid && o_ready;
		pop  = o_valid && i_ready;
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
		if (push)
			mem_q[wp_q[AW-1:0]] <= i_data;
	end

	assign o_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
	assign o_valid = (wp_q != rp_q);
	assign o_data  = mem_q[rp_q[AW-1:0]];
endmodule // dhi_fifo

// file: rtl/dhi_device.sv
// Display port end: decodes parallel and serial host transfers into writes
// Assumes pins arrive asynchronously; they are synchronised to i_mclk
`timescale 1ns/1ps
module dhi_device #(
	parameter int DEPTH = dhi_pkg::FIFO_DEPTH
) (
	input  wire logic       i_mclk,
	input  wire logic       i_nrst,
	dhi_if.dev              bus,
	output logic [7:0]      o_wr_byte,
	output logic            o_wr_is_data,
	output logic            o_wr_valid,
	input  wire logic       i_wr_ready,
	input  wire logic [7:0] i_status,
	input  wire logic [7:0] i_ram_rd,
	output logic            o_ram_rd_next,
	output logic [2:0]      o_mode
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int PW = 8 + 5 + 3;
	logic [PW-1:0] s1_q, s2_q, pv_q;
	always_ff @(posedge i_mclk) begin
		s1_q <= {bus.reset_input_n, bus.interface_select_straps, bus.cs_n, bus.dc,
			bus.e_rd_n, bus.rw_wr_n, bus.d_in_dev};
		s2_q <= s1_q;
		pv_q <= s2_q;
	end
	logic [7:0] pd;
	logic       p_e, p_rw, p_dc, p_cs, p_rst, e_prev, rw_prev, sck_prev;
	logic [2:0] pmode;
	always_comb begin
		pd       = s2_q[7:0];
		p_rw     = s2_q[8];
		p_e      = s2_q[9];
		p_dc     = s2_q[10];
		p_cs     = s2_q[11];
		pmode    = s2_q[14:12];
		p_rst    = s2_q[15];
		rw_prev  = pv_q[8];
		e_prev   = pv_q[9];
		sck_prev = pv_q[0];
	end

	// ------------------------------------------------------------
	// Transfer decode
	// ------------------------------------------------------------
	logic       rst;
	logic [2:0] mode_q, mode_d;
	logic [8:0] sh_q, sh_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] rd_q, rd_d;
	logic       drive_q, drive_d, dummy_q, dummy_d, rdnx_q, rdnx_d;
	logic [8:0] push_data;
	logic       push, fifo_ready, sel;
	logic       e_fall, wr_rise, rd_rise, sck_rise, rd_open;
	always_comb begin
		rst      = !i_nrst || !p_rst;
		sel      = !p_cs;
		e_fall   = e_prev && !p_e;
		wr_rise  = !rw_prev && p_rw;
		rd_rise  = !e_prev && p_e;
		sck_rise = !sck_prev && pd[0];
		mode_d   = pmode;
		sh_d     = sh_q;
		cnt_d    = cnt_q;
		rd_d     = rd_q;
		dummy_d  = dummy_q;
		rdnx_d   = 1'b0;
		push     = 1'b0;
		push_data = '0;
		rd_open  = 1'b0;
		if (!sel)
			cnt_d = '0;
		case (mode_q)
			dhi_pkg::SEL_PAR_EN: begin
				rd_open = sel && p_rw && p_e;
				if (sel && e_fall) begin
					if (!p_rw) begin
						push = 1'b1;
						push_data = {p_dc, pd};
					end else if (p_dc) begin
						// Prefetch the next word each read; the first one shows stale data
						rd_d = i_ram_rd;
						dummy_d = 1'b0;
						rdnx_d = 1'b1;
					end
				end
			end
			dhi_pkg::SEL_PAR_SEP: begin
				rd_open = sel && !p_e;
				if (sel && wr_rise && p_e) begin
					push = 1'b1;
					push_data = {p_dc, pd};
				end else if (sel && rd_rise && p_rw && p_dc) begin
					dummy_d = 1'b0;
					rdnx_d = 1'b1;
				end
			end
			dhi_pkg::SEL_SPI4: begin
				if (sel && sck_rise) begin
					sh_d = {sh_q[7:0], pd[1]};
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == 4'(dhi_pkg::SPI_BITS - 1)) begin
						cnt_d = '0;
						push = 1'b1;
						push_data = {p_dc, sh_q[6:0], pd[1]};
					end
				end
			end
			dhi_pkg::SEL_SPI3: begin
				if (sel && sck_rise) begin
					sh_d = {sh_q[7:0], pd[1]};
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == 4'(dhi_pkg::SPI3_BITS - 1)) begin
						cnt_d = '0;
						push = 1'b1;
						push_data = {sh_q[7:0], pd[1]};
					end
				end
			end
			default: ; // I2C and unused codes: no transfer decoded here
		endcase
		if (!sel)
			dummy_d = dummy_q;
		if (push && p_dc && mode_q != dhi_pkg::SEL_PAR_EN)
			dummy_d = 1'b1;
		if (push)
			dummy_d = 1'b1; // A write restarts the read pipeline
		drive_d = rd_open;
		if (mode_q == dhi_pkg::SEL_PAR_SEP && rd_open && !drive_q)
			rd_d = p_dc ? (dummy_q ? dhi_pkg::RAM_RST : i_ram_rd) : i_status;
		if (mode_q == dhi_pkg::SEL_PAR_EN && rd_open && !drive_q && !p_dc)
			rd_d = i_status;
	end

	always_ff @(posedge i_mclk) begin
		if (rst) begin
			mode_q  <= dhi_pkg::SEL_PAR_SEP;
			sh_q    <= '0;
			cnt_q   <= '0;
			rd_q    <= dhi_pkg::STATUS_RST;
			drive_q <= 1'b0;
			dummy_q <= 1'b1;
			rdnx_q  <= 1'b0;
		end else begin
			mode_q  <= mode_d;
			sh_q    <= sh_d;
			cnt_q   <= cnt_d;
			rd_q    <= rd_d;
			drive_q <= drive_d;
			dummy_q <= dummy_d;
			rdnx_q  <= rdnx_d;
		end
	end

	// ------------------------------------------------------------
	// Write buffer toward command decoder and display RAM
	// ------------------------------------------------------------
	logic [8:0] f_data;
	logic       f_valid;
	dhi_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
		.i_mclk (i_mclk),
		.i_nrst (!rst),
		.i_data (push_data),
		.i_valid(push),
		.o_ready(fifo_ready),
		.o_data (f_data),
		.o_valid(f_valid),
		.i_ready(i_wr_ready && !o_wr_valid)
	);

	logic [7:0] ob_q, ob_d;
	logic       od_q, od_d, ov_q, ov_d;
	always_comb begin
		ob_d = ob_q;
		od_d = od_q;
		ov_d = 1'b0;
		if (f_valid && i_wr_ready && !ov_q) begin
			ob_d = f_data[7:0];
			od_d = f_data[8];
			ov_d = 1'b1;
		end
	end
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			ob_q <= '0;
			od_q <= 1'b0;
			ov_q <= 1'b0;
		end else begin
			ob_q <= ob_d;
			od_q <= od_d;
			ov_q <= ov_d;
		end
	end

	assign o_wr_byte      = ob_q;
	assign o_wr_is_data   = od_q;
	assign o_wr_valid     = ov_q;
	assign o_ram_rd_next  = rdnx_q;
	assign o_mode         = mode_q;
	assign bus.d_dev      = rd_q;
	assign bus.d_dev_oe_n = {8{!drive_q}};
endmodule // dhi_device

// file: rtl/dhi_host.sv
// Host end: turns user requests into parallel or serial pin sequences
// Assumes the device end samples pins on its own clock
`timescale 1ns/1ps
module dhi_host (
	input  wire logic       i_mclk,
	input  wire logic       i_nrst,
	dhi_if.host             bus,
	input  wire logic [2:0] i_mode,
	input  wire logic       i_req,
	input  wire logic [1:0] i_op,
	input  wire logic [7:0] i_wdata,
	output logic            o_busy,
	output logic [7:0]      o_rdata,
	output logic            o_rdone
);
	typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF, ST_END} st_t;
	st_t        st_q, st_d;
	logic [4:0] tm_q, tm_d;
	logic [3:0] bit_q, bit_d;
	logic [8:0] sh_q, sh_d;
	logic [1:0] op_q, op_d;
	logic       sck_q, sck_d, stb_q, stb_d, rdone_d, rdone_q;
	logic [7:0] rdat_q, rdat_d, rin1_q, rin2_q;
	logic       ser, rd;

	always_ff @(posedge i_mclk) begin
		rin1_q <= bus.d_in_host;
		rin2_q <= rin1_q;
	end

	always_comb begin
		ser     = i_mode == dhi_pkg::SEL_SPI4 || i_mode == dhi_pkg::SEL_SPI3;
		rd      = op_q[1];
		st_d    = st_q;
		tm_d    = tm_q + 5'h1;
		bit_d   = bit_q;
		sh_d    = sh_q;
		op_d    = op_q;
		sck_d   = sck_q;
		stb_d   = stb_q;
		rdat_d  = rdat_q;
		rdone_d = 1'b0;
		case (st_q)
			ST_IDLE: begin
				tm_d = '0;
				if (i_req && !(ser && i_op[1])) begin
					op_d  = i_op;
					bit_d = (i_mode == dhi_pkg::SEL_SPI3) ? 4'(dhi_pkg::SPI3_BITS)
						: 4'(dhi_pkg::SPI_BITS);
					sh_d  = (i_mode == dhi_pkg::SEL_SPI3) ? {i_op[0], i_wdata}
						: {1'b0, i_wdata};
					st_d  = ST_ON;
				end
			end
			ST_ON: begin
				stb_d = 1'b1;
				sck_d = 1'b0;
				if (tm_q == 5'(dhi_pkg::DIV_HALF)) begin
					tm_d = '0;
					st_d = ST_OFF;
					if (rd)
						rdat_d = rin2_q;
				end
			end
			ST_OFF: begin
				stb_d = 1'b0;
				sck_d = 1'b1;
				if (tm_q == 5'(dhi_pkg::DIV_HALF)) begin
					tm_d  = '0;
					sh_d  = {sh_q[7:0], 1'b0};
					bit_d = bit_q - 4'h1;
					st_d  = (!ser || bit_q == 4'h1) ? ST_END : ST_ON;
				end
			end
			default: begin
				sck_d = 1'b0;
				rdone_d = rd;
				st_d  = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			st_q    <= ST_IDLE;
			tm_q    <= '0;
			bit_q   <= '0;
			sh_q    <= '0;
			op_q    <= '0;
			sck_q   <= 1'b0;
			stb_q   <= 1'b0;
			rdat_q  <= '0;
			rdone_q <= 1'b0;
		end else begin
			st_q    <= st_d;
			tm_q    <= tm_d;
			bit_q   <= bit_d;
			sh_q    <= sh_d;
			op_q    <= op_d;
			sck_q   <= sck_d;
			stb_q   <= stb_d;
			rdat_q  <= rdat_d;
			rdone_q <= rdone_d;
		end
	end

	logic par_en, active, sdo;
	assign par_en  = i_mode == dhi_pkg::SEL_PAR_EN;
	assign active  = st_q != ST_IDLE;
	// Three-wire frames lead with the flag, so the outgoing bit sits one place higher
	assign sdo     = (i_mode == dhi_pkg::SEL_SPI3) ? sh_q[8] : sh_q[7];
	assign bus.interface_select_straps = i_mode;
	assign bus.reset_input_n = i_nrst;
	assign bus.cs_n    = !active;
	assign bus.dc      = (i_mode == dhi_pkg::SEL_SPI3) ? 1'b0 : op_q[0];
	// Enable mode: strobe high then falls; separate mode: low-active read strobe
	assign bus.e_rd_n  = ser ? 1'b0 : par_en ? (stb_q && active)
		: !(stb_q && rd && active);
	assign bus.rw_wr_n = ser ? 1'b0 : par_en ? rd : !(stb_q && !rd && active);
	// SPI: clock on line 0, data on lines 1 and 2 together, others low
	assign bus.d_host  = ser ? {5'h00, sdo, sdo, sck_q} : sh_q[7:0];
	assign bus.d_host_oe_n = {8{rd && !ser}};
	assign o_busy  = active;
	assign o_rdata = rdat_q;
	assign o_rdone = rdone_q;
endmodule // dhi_host

// file: testbench/dhi_monitor.sv
// Checker on the pins between the host end and the display port end
// Assumes it sits beside the pin bundle and shares the system clock
`timescale 1ns/1ps
module dhi_monitor (
	input  wire logic       i_mclk,
	input  wire logic       i_nrst,
	input  wire logic [7:0] i_d_host_oe_n,
	input  wire logic [7:0] i_d_dev_oe_n,
	input  wire logic       i_cs_n,
	input  wire logic       i_dc,
	input  wire logic       i_e_rd_n,
	input  wire logic       i_rw_wr_n,
	input  wire logic [2:0] i_straps
);
	logic       drv, ser, cs_n, dc, e_rd_n, rw_wr_n;
	logic [7:0] d_host_oe_n;
	logic [2:0] s;
	assign drv         = (i_d_dev_oe_n != 8'hFF);
	assign s           = i_straps;
	assign ser         = (s == dhi_pkg::SEL_SPI4) || (s == dhi_pkg::SEL_SPI3);
	assign cs_n        = i_cs_n;
	assign dc          = i_dc;
	assign e_rd_n      = i_e_rd_n;
	assign rw_wr_n     = i_rw_wr_n;
	assign d_host_oe_n = i_d_host_oe_n;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	property p_rel; drv |-> !cs_n; endproperty
	a_rel: assert property (p_rel) else $error("device drives unselected");
	property p_fight; drv |-> (&d_host_oe_n); endproperty
	a_fight: assert property (p_fight) else $error("both ends drive");
	property p_ser; ser |-> !drv; endproperty
	a_ser: assert property (p_ser) else $error("serial mode read");
	property p_en_rd; (s == dhi_pkg::SEL_PAR_EN) && drv |-> rw_wr_n; endproperty
	a_en_rd: assert property (p_en_rd) else $error("drive while write");
	property p_sep_rd; (s == dhi_pkg::SEL_PAR_SEP) && drv |-> rw_wr_n; endproperty
	a_sep_rd: assert property (p_sep_rd) else $error("write strobe low in read");
	property p_sep_wr; (s == dhi_pkg::SEL_PAR_SEP) && !rw_wr_n |-> e_rd_n; endproperty
	a_sep_wr: assert property (p_sep_wr) else $error("read strobe low in write");
	property p_grd; ser && !cs_n |-> !e_rd_n && !rw_wr_n; endproperty
	a_grd: assert property (p_grd) else $error("strobes not grounded");
	property p_dc; (s == dhi_pkg::SEL_SPI4) && !cs_n && !$past(cs_n) |-> $stable(dc); endproperty
	a_dc: assert property (p_dc) else $error("select moved in byte");
	property p_stb; $fell(e_rd_n) && (s == dhi_pkg::SEL_PAR_SEP) |-> !e_rd_n[*8]; endproperty
	a_stb: assert property (p_stb) else $error("read strobe too short");
	property p_en_cs; (s == dhi_pkg::SEL_PAR_EN) && e_rd_n |-> !cs_n; endproperty
	a_en_cs: assert property (p_en_cs) else $error("enable without select");
endmodule // dhi_monitor

// file: testbench/display_host_interface_tb.sv
// Bench joining the host end to the display port end through the pin bundle
// Assumes released data lines fall to low; no partner model
`timescale 1ns/1ps
module display_host_interface_tb;
	logic       i_mclk    = 1'b0;
	logic       i_nrst    = 1'b0;
	logic [2:0] mode      = dhi_pkg::SEL_PAR_EN;
	logic       req       = 1'b0;
	logic [1:0] op        = 2'h0;
	logic [7:0] wdata     = 8'h00;
	logic       rdy       = 1'b1;
	logic       busy;
	logic       rdone;
	logic       wr_valid;
	logic       wr_is_data;
	logic [7:0] rdata;
	logic [7:0] wr_byte;
	logic [2:0] dev_mode;
	logic [7:0] rd_val;
	logic       rd_next;
	logic [8:0] got_q[$];
	int         rd_cnt    = 0;
	int         err_count = 0;
	int         checked   = 0;
	int         nx_cnt    = 0;
	dhi_if bus ();
	assign bus.d_in_host = (~bus.d_dev_oe_n & bus.d_dev) | (~bus.d_host_oe_n & bus.d_host);
	assign bus.d_in_dev  = bus.d_in_host;
	always #4 i_mclk = ~i_mclk;
	always @(negedge i_mclk) begin
		if (wr_valid === 1'b1 && rdy) got_q.push_back({wr_is_data, wr_byte});
		if (rd_next === 1'b1) nx_cnt++;
		if (rdone === 1'b1) begin
			rd_cnt++;
			rd_val = rdata;
		end
	end
	dhi_device dhi_device_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .bus(bus.dev),
		.o_wr_byte(wr_byte), .o_wr_is_data(wr_is_data), .o_wr_valid(wr_valid),
		.i_wr_ready(rdy), .i_status(8'h5A), .i_ram_rd(8'hC3), .o_ram_rd_next(rd_next),
		.o_mode(dev_mode));
	dhi_host dhi_host_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .bus(bus.host), .i_mode(mode),
		.i_req(req), .i_op(op), .i_wdata(wdata), .o_busy(busy), .o_rdata(rdata),
		.o_rdone(rdone));
	dhi_monitor dhi_monitor_inst (.i_mclk(i_mclk), .i_nrst(i_nrst),
		.i_d_host_oe_n(bus.d_host_oe_n), .i_d_dev_oe_n(bus.d_dev_oe_n), .i_cs_n(bus.cs_n),
		.i_dc(bus.dc), .i_e_rd_n(bus.e_rd_n), .i_rw_wr_n(bus.rw_wr_n),
		.i_straps(bus.interface_select_straps));
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_wr(input logic [8:0] e);
		logic [8:0] g;
		g = got_q.pop_front();
		chk8(g[7:0], e[7:0]);
		chk8({7'h0, g[8]}, {7'h0, e[8]});
	endtask
	task xfer(input logic [1:0] o, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge i_mclk);
		req = 1'b1;
		op = o;
		wdata = d;
		while (busy !== 1'b1 && n < 50) begin
			@(negedge i_mclk);
			n++;
		end
		req = 1'b0;
		while (busy === 1'b1 && n < 3000) begin
			@(negedge i_mclk);
			n++;
		end
		repeat (12) @(negedge i_mclk);
	endtask
	task set_mode(input logic [2:0] m);
		@(negedge i_mclk);
		mode = m;
		repeat (12) @(negedge i_mclk);
		chk8({5'h0, dev_mode}, {5'h0, m});
		got_q.delete();
		rd_cnt = 0;
		nx_cnt = 0;
	endtask
	task t_write;
		logic [2:0] ms[4];
		ms = '{dhi_pkg::SEL_PAR_EN, dhi_pkg::SEL_PAR_SEP, dhi_pkg::SEL_SPI4,
			dhi_pkg::SEL_SPI3};
		for (int i = 0; i < 4; i++) begin
			set_mode(ms[i]);
			xfer(dhi_pkg::OP_WR_CMD, 8'hA1);
			xfer(dhi_pkg::OP_WR_DATA, 8'h3C + 8'(i));
			chk_wr(9'h0A1);
			chk_wr({1'b1, 8'h3C + 8'(i)});
		end
		$display("t_write done");
	endtask
	task t_read;
		logic [2:0] ms[2];
		ms = '{dhi_pkg::SEL_PAR_EN, dhi_pkg::SEL_PAR_SEP};
		for (int i = 0; i < 2; i++) begin
			set_mode(ms[i]);
			xfer(dhi_pkg::OP_WR_CMD, 8'hAE);
			xfer(dhi_pkg::OP_RD_STATUS, 8'h00);
			chk8(rd_val, 8'h5A);
			xfer(dhi_pkg::OP_RD_DATA, 8'h00);
			xfer(dhi_pkg::OP_RD_DATA, 8'h00);
			chk8(rd_val, 8'hC3);
			chk8(8'(rd_cnt), 8'h03);
			chk8(8'(nx_cnt), 8'h02);
			chk_wr(9'h0AE);
			chk8(8'(got_q.size()), 8'h00);
		end
		$display("t_read done");
	endtask
	task t_serial_read;
		set_mode(dhi_pkg::SEL_SPI4);
		xfer(dhi_pkg::OP_RD_STATUS, 8'h00);
		xfer(dhi_pkg::OP_RD_DATA, 8'h00);
		chk8(8'(rd_cnt), 8'h00);
		chk8(8'(got_q.size()), 8'h00);
		chk8(8'(nx_cnt), 8'h00);
		$display("t_serial_read done");
	endtask
	task t_reset;
		set_mode(dhi_pkg::SEL_PAR_SEP);
		@(negedge i_mclk);
		i_nrst = 1'b0;
		repeat (20) @(negedge i_mclk);
		i_nrst = 1'b1;
		repeat (4) @(negedge i_mclk);
		chk8({5'h0, dev_mode}, {5'h0, dhi_pkg::SEL_PAR_SEP});
		xfer(dhi_pkg::OP_RD_DATA, 8'h00);
		xfer(dhi_pkg::OP_RD_DATA, 8'h00);
		chk8(rd_val, 8'hC3);
		chk8(8'(rd_cnt), 8'h02);
		chk8(8'(nx_cnt), 8'h02);
		$display("t_reset done");
	endtask
	task t_fifo;
		set_mode(dhi_pkg::SEL_PAR_SEP);
		rdy = 1'b0;
		for (int i = 0; i < 10; i++) xfer(dhi_pkg::OP_WR_DATA, 8'h10 + 8'(i));
		@(negedge i_mclk);
		rdy = 1'b1;
		repeat (40) @(negedge i_mclk);
		for (int i = 0; i < 8; i++) chk_wr({1'b1, 8'h10 + 8'(i)});
		chk8(8'(got_q.size()), 8'h00);
		$display("t_fifo done");
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#400000;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		final_report;
	end
	initial begin
		repeat (20) @(negedge i_mclk);
		i_nrst = 1'b1;
		repeat (4) @(negedge i_mclk);
		t_write;
		t_read;
		t_serial_read;
		t_reset;
		t_fifo;
		final_report;
	end
endmodule // display_host_interface_tb
